//--- rtl/vpfc_cfg.svh
`ifndef VPFC_CFG_SVH
`define VPFC_CFG_SVH
`define VPFC_OFS_G0_LOW 8'h60
`define VPFC_OFS_G0_HIGH 8'h61
`define VPFC_OFS_G1_LOW 8'h62
`define VPFC_OFS_G1_HIGH 8'h63
`define VPFC_OFS_DEV 8'h64
`define VPFC_RST_G0_LOW 8'h26
`define VPFC_RST_G0_HIGH 8'h31
`define VPFC_RST_G1_LOW 8'h70
`define VPFC_RST_G1_HIGH 8'h3d
`define VPFC_RST_DEV 8'hff
`define VPFC_BUILTIN_G0 15'h3126
`define VPFC_BUILTIN_G1 15'h3d70
`define VPFC_OVR_BIT 7
`define VPFC_REF_HZ 25000000
`define VPFC_SYS_HZ 40000000
`define VPFC_WIN_CYC 11'h400
`define VPFC_VCO_DIV 32
`endif

//--- rtl/vpfc_pkg.sv
package vpfc_pkg;
  typedef struct packed {
    logic [14:0] target;
    logic [3:0] dev;
  } vpfc_grp_t;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } vpfc_reg_req_t;
endpackage : vpfc_pkg

//--- rtl/vpfc_ref_tick.sv
`include "vpfc_cfg.svh"
// 25 MHz reference tick from the 40 MHz clock: fractional accumulator
module vpfc_ref_tick (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  output logic o_tick
);
  localparam logic [25:0] STEP = 26'(`VPFC_REF_HZ);
  localparam logic [25:0] MODV = 26'(`VPFC_SYS_HZ);
  // start phase: first tick on the first edge, so reset never leaves two idle cycles
  localparam logic [25:0] ACC_RST = MODV - STEP;
  logic [25:0] acc_q;
  logic [26:0] sum;
  assign sum = {1'b0, acc_q} + {1'b0, STEP};
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      acc_q <= ACC_RST;
      o_tick <= 1'b0;
    end
    else if (sum >= {1'b0, MODV})
    begin
      acc_q <= 26'(sum - {1'b0, MODV});
      o_tick <= 1'b1;
    end
    else
    begin
      acc_q <= sum[25:0];
      o_tick <= 1'b0;
    end
  end
endmodule : vpfc_ref_tick

//--- rtl/vpfc_top.sv
`include "vpfc_cfg.svh"
// Summary of operation
// - the measurement window is timed by a reference tick that always runs at 25 MHz.
// - each window lasts 1024 reference ticks and counts edges of the vco divided by 32.
// - group 0 target is 15 bits: high register bits 6:0 over low register bits 7:0.
// - group 1 target is 15 bits: high register bits 6:0 over low register bits 7:0.
// - bit 7 of the group 0 high register selects the programmed target over the built-in.
// - bit 7 of the group 1 high register selects the programmed target over the built-in.
// - group 0 deviation is bits 7:4 of the delta register, 0 to 15.
// - group 1 deviation is bits 3:0 of the delta register, 0 to 15.
module vpfc_top (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_vco_div32,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic [14:0] o_meas_count,
  output logic o_meas_done,
  output logic o_grp0_match,
  output logic o_grp1_match
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic in_band(input logic [14:0] cnt, input vpfc_pkg::vpfc_grp_t g);
    logic [15:0] lo;
    logic [15:0] hi;
    lo = {1'b0, g.target} - {12'h000, g.dev};
    hi = {1'b0, g.target} + {12'h000, g.dev};
    if (lo[15])
      lo = 16'h0000;
    in_band = ({1'b0, cnt} >= lo) && ({1'b0, cnt} <= hi);
  endfunction : in_band

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_COUNT = 2'b10
  } vpfc_state_t;

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] g0_low_q;
  logic [7:0] g0_high_q;
  logic [7:0] g1_low_q;
  logic [7:0] g1_high_q;
  logic [7:0] dev_q;
  vpfc_pkg::vpfc_reg_req_t req;
  assign req = '{wr: i_reg_wr, addr: i_reg_addr, wdata: i_reg_wdata};

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      g0_low_q <= `VPFC_RST_G0_LOW;
      g0_high_q <= `VPFC_RST_G0_HIGH;
      g1_low_q <= `VPFC_RST_G1_LOW;
      g1_high_q <= `VPFC_RST_G1_HIGH;
      dev_q <= `VPFC_RST_DEV;
    end
    else if (req.wr)
    begin
      case (req.addr)
        `VPFC_OFS_G0_LOW: g0_low_q <= req.wdata;
        `VPFC_OFS_G0_HIGH: g0_high_q <= req.wdata;
        `VPFC_OFS_G1_LOW: g1_low_q <= req.wdata;
        `VPFC_OFS_G1_HIGH: g1_high_q <= req.wdata;
        `VPFC_OFS_DEV: dev_q <= req.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
      o_reg_rdata <= 8'h00;
    else
    begin
      case (i_reg_addr)
        `VPFC_OFS_G0_LOW: o_reg_rdata <= g0_low_q;
        `VPFC_OFS_G0_HIGH: o_reg_rdata <= g0_high_q;
        `VPFC_OFS_G1_LOW: o_reg_rdata <= g1_low_q;
        `VPFC_OFS_G1_HIGH: o_reg_rdata <= g1_high_q;
        `VPFC_OFS_DEV: o_reg_rdata <= dev_q;
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  vpfc_pkg::vpfc_grp_t grp0;
  vpfc_pkg::vpfc_grp_t grp1;
  logic [14:0] g0_prog;
  logic [14:0] g1_prog;
  assign g0_prog = {g0_high_q[6:0], g0_low_q};
  assign g1_prog = {g1_high_q[6:0], g1_low_q};
  assign grp0 = '{
    target: g0_high_q[`VPFC_OVR_BIT] ? g0_prog : `VPFC_BUILTIN_G0,
    dev: dev_q[7:4]
  };
  assign grp1 = '{
    target: g1_high_q[`VPFC_OVR_BIT] ? g1_prog : `VPFC_BUILTIN_G1,
    dev: dev_q[3:0]
  };

  ////////////////////////////////////////////////////////////////////////////
  logic ref_tick;
  vpfc_ref_tick u_tick (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .o_tick(ref_tick)
  );

  logic vco_s1_q;
  logic vco_s2_q;
  logic vco_s3_q;
  logic vco_edge;
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      vco_s1_q <= 1'b0;
      vco_s2_q <= 1'b0;
      vco_s3_q <= 1'b0;
    end
    else
    begin
      vco_s1_q <= i_vco_div32;
      vco_s2_q <= vco_s1_q;
      vco_s3_q <= vco_s2_q;
    end
  end
  assign vco_edge = vco_s2_q && !vco_s3_q;

  ////////////////////////////////////////////////////////////////////////////
  vpfc_state_t state_q;
  logic [10:0] win_q;
  logic [14:0] cnt_q;
  logic win_end;
  assign win_end = (state_q == ST_COUNT) && ref_tick && (win_q == `VPFC_WIN_CYC - 11'h001);

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      state_q <= ST_IDLE;
      win_q <= 11'h000;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (ref_tick)
          begin
            state_q <= ST_COUNT;
            win_q <= 11'h000;
          end
        end
        ST_COUNT:
        begin
          if (win_end)
            win_q <= 11'h000;
          else if (ref_tick)
            win_q <= win_q + 11'h001;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
      cnt_q <= 15'h0000;
    else if (win_end)
      cnt_q <= {14'h0000, vco_edge};
    else if (state_q == ST_COUNT && vco_edge && cnt_q != 15'h7fff)
      cnt_q <= cnt_q + 15'h0001;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      o_meas_count <= 15'h0000;
      o_meas_done <= 1'b0;
      o_grp0_match <= 1'b0;
      o_grp1_match <= 1'b0;
    end
    else
    begin
      o_meas_done <= win_end;
      if (win_end)
      begin
        o_meas_count <= cnt_q;
        o_grp0_match <= in_band(cnt_q, grp0);
        o_grp1_match <= in_band(cnt_q, grp1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_WIN_LEN: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    win_end |-> ##1 (!win_end [*8]))
    else $error("window ended twice too close");
  AST_DONE_PULSE: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    win_end |=> o_meas_done && o_meas_count == $past(cnt_q))
    else $error("measured count not published");
  AST_TICK_RATE: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    ref_tick |=> !ref_tick || $past(ref_tick, 2) == 1'b0)
    else $error("reference tick too dense");
  AST_TICK_GAP: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !ref_tick |=> ref_tick)
    else $error("reference tick too sparse");
  AST_G0_SEL: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    g0_high_q[7] |-> grp0.target == {g0_high_q[6:0], g0_low_q})
    else $error("group 0 override not applied");
  AST_G1_SEL: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !g1_high_q[7] |-> grp1.target == `VPFC_BUILTIN_G1)
    else $error("group 1 builtin not used");
  AST_G0_WR: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (i_reg_wr && i_reg_addr == `VPFC_OFS_G0_LOW) |=> g0_low_q == $past(i_reg_wdata))
    else $error("group 0 low write lost");
  AST_DEV_WR: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (i_reg_wr && i_reg_addr == `VPFC_OFS_DEV) |=> grp0.dev == $past(i_reg_wdata[7:4])
      && grp1.dev == $past(i_reg_wdata[3:0]))
    else $error("deviation write lost");
  AST_MATCH: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (win_end && cnt_q == grp1.target) |=> o_grp1_match)
    else $error("exact target not matched");
endmodule : vpfc_top

//--- testbench/vpfc_top_tb.sv
module vpfc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic i_reg_wr = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic [7:0] o_reg_rdata;
  logic [14:0] o_meas_count;
  logic o_meas_done;
  logic o_grp0_match;
  logic o_grp1_match;
  logic vco_en = 1'b0;
  logic [2:0] ph = 3'h0;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int gap;
  always #12.5 i_clk_sys = ~i_clk_sys;
  // divided vco: 8 clock period, 5 MHz
  always @(posedge i_clk_sys) ph <= #1 ph + 3'h1;
  vpfc_top dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_vco_div32(vco_en & ph[2]),
    .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_meas_count(o_meas_count), .o_meas_done(o_meas_done),
    .o_grp0_match(o_grp0_match), .o_grp1_match(o_grp1_match));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    #1 i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(posedge i_clk_sys);
    #1 i_reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    #1 i_reg_addr = a;
    @(posedge i_clk_sys);
    #2 d = o_reg_rdata;
  endtask : rd
  task automatic wait_done(output int n);
    n = 0;
    do
    begin
      @(posedge i_clk_sys);
      #2 n++;
    end
    while (o_meas_done !== 1'b1 && n < 2000);
  endtask : wait_done
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_regs;
    logic [7:0] d;
    logic [7:0] vals [5] = '{8'h26, 8'h31, 8'h70, 8'h3d, 8'hff};
    logic [7:0] cfg [5] = '{8'hc4, 8'hb1, 8'hc4, 8'hb1, 8'hcc};
    `CHK({o_meas_done, o_grp0_match, o_grp1_match, o_meas_count}, 18'h0)
    for (int i = 0; i < 5; i++)
    begin
      rd(8'h60 + 8'(i), d);
      `CHK(d, vals[i])
    end
    for (int i = 0; i < 5; i++)
      wr(8'h60 + 8'(i), cfg[i]);
    wr(8'h65, 8'h5a);
    for (int i = 0; i < 5; i++)
    begin
      rd(8'h60 + 8'(i), d);
      `CHK(d, cfg[i])
    end
    rd(8'h65, d);
    `CHK(d, 8'h00)
    $display("register test done");
  endtask : test_regs
  task automatic test_window;
    @(posedge i_clk_sys);
    #1 vco_en = 1'b1;
    wait_done(gap);
    wait_done(gap);
    `CHK(gap inside {1638, 1639}, 1'b1)
    `CHK(o_meas_count inside {15'd204, 15'd205}, 1'b1)
    $display("window test done");
  endtask : test_window
  task automatic settle(input logic e0, input logic e1);
    wait_done(gap);
    wait_done(gap);
    `CHK(o_grp0_match, e0)
    `CHK(o_grp1_match, e1)
  endtask : settle
  task automatic test_match;
    // programmed 207 but override off: builtins are far away
    wr(8'h60, 8'hcf);
    wr(8'h61, 8'h00);
    wr(8'h62, 8'hcf);
    wr(8'h63, 8'h00);
    wr(8'h64, 8'hff);
    settle(1'b0, 1'b0);
    wr(8'h61, 8'h80);
    wr(8'h63, 8'h80);
    wr(8'h64, 8'h31);
    settle(1'b1, 1'b0);
    wr(8'h64, 8'h13);
    settle(1'b0, 1'b1);
    // deviation 15 around 219 reaches 204
    wr(8'h60, 8'hdb);
    wr(8'h64, 8'hf0);
    settle(1'b1, 1'b0);
    $display("match test done");
  endtask : test_match
  task automatic test_floor;
    // vco stopped: zero count, group 1 target 0 with low bound clamped
    @(posedge i_clk_sys);
    #1 vco_en = 1'b0;
    wr(8'h62, 8'h00);
    wr(8'h63, 8'h80);
    wr(8'h64, 8'h03);
    settle(1'b0, 1'b1);
    `CHK(o_meas_count, 15'h0000)
    $display("floor test done");
  endtask : test_floor
  initial
  begin
    repeat (3) @(posedge i_clk_sys);
    #1 i_nrst = 1'b1;
    test_regs();
    test_window();
    test_match();
    test_floor();
    wrap_up();
  end
endmodule : vpfc_top_tb
